/* File: logic/sleep_power_reset_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sleep_power_reset_control_defines.svh"

module sleep_power_reset_control
#(
   parameter int unsigned     PIN_N       = 8,
   parameter int unsigned     CNT_W       = 20,
   parameter logic [CNT_W-1:0] TOUT_SUT0  = 20'h00006,
   parameter logic [CNT_W-1:0] TOUT_SUT1  = 20'h0a028,
   parameter logic [CNT_W-1:0] TOUT_SUT2  = 20'h9eb10,
   parameter logic [CNT_W-1:0] TOUT_SUT3  = 20'h00006,
   parameter logic [CNT_W-1:0] XTAL_EXTRA = 20'h04000,
   parameter logic [14:0]     BOOT_BASE0  = 15'h3f00,
   parameter logic [14:0]     BOOT_BASE1  = 15'h3e00,
   parameter logic [14:0]     BOOT_BASE2  = 15'h3c00,
   parameter logic [14:0]     BOOT_BASE3  = 15'h3800
)
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [15:0]       dataAddr,
   input  wire logic              dataWrite,
   input  wire logic              dataRead,
   input  wire logic [5:0]        ioAddr,
   input  wire logic              ioWrite,
   input  wire logic              ioRead,
   input  wire logic [7:0]        writeData,
   output logic      [7:0]        readData,
   input  wire logic              sleepInstr,
   input  wire logic              wakeEvent,
   input  wire logic              instrRetire,
   output logic                   cpuHalt,
   output logic      [2:0]        sleepModeField,
   output logic                   brownoutDetectorOn,
   input  wire logic [PIN_N-1:0]  pinDirection,
   input  wire logic [PIN_N-1:0]  pinOutputValue,
   output logic      [PIN_N-1:0]  pullupEnable,
   output logic                   portResetForce,
   input  wire logic [1:0]        bootAreaSizeFuse,
   input  wire logic              appSideBootLock,
   input  wire logic              bootSideBootLock,
   input  wire logic              execFromBoot,
   output logic      [14:0]       vectorBase,
   output logic                   interruptBlock,
   input  wire logic              timer2AsyncSelect,
   output logic                   gateTwoWire0,
   output logic                   gateTimer2,
   output logic                   gateTimer0,
   output logic                   gateSerialPort1,
   output logic                   gateTimer1,
   output logic                   gateSerialPeripheral0,
   output logic                   gateSerialPort0,
   output logic                   gateConverter,
   output logic                   comparatorMuxBlock,
   input  wire logic              powerOnDetect,
   input  wire logic              extReset_n,
   input  wire logic              watchdogExpire,
   input  wire logic              watchdogResetMode,
   input  wire logic              brownoutDetect,
   input  wire logic              brownoutEnable,
   input  wire logic [1:0]        startupTimeFuse,
   input  wire logic [3:0]        clockSourceFuse,
   output logic                   internalReset
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed
   {
      logic [2:0]                               sleepModeField;
      logic                                     sleepEnable;
      logic                                     brownoutSleepOff;
      logic [2:0]                               bodsTimer;
      logic [2:0]                               bodUnlockTimer;
      logic                                     pullupDisable;
      logic                                     vectorSelect;
      logic [2:0]                               vectorUnlockTimer;
      logic                                     maskHold;
      logic [7:0]                               clockGate;
      logic [7:0]                               readData;
      sleep_power_reset_control_pkg::cpu_state_t cpuState;
      logic [CNT_W-1:0]                         wakeCount;
      logic                                     bodOff;
      logic                                     rstSync1;
      logic                                     rstSync2;
      logic [CNT_W-1:0]                         delayCount;
      logic                                     internalReset;
   } state_t;

   state_t           cur;
   state_t           next_cur;
   logic             rawReset;
   logic [15:0]      regAddr;
   logic             regWrite;
   logic             regRead;
   logic             bodsActive;
   logic             bodUnlockOpen;
   logic             vectorUnlockOpen;
   logic             modeValid;
   logic [CNT_W-1:0] timeoutSel;

   // ****************************************************************
   // reset sources
   // ****************************************************************
   // pin term is combinational on purpose: port force must work clockless
   assign rawReset = powerOnDetect | ~extReset_n
                   | (watchdogExpire & watchdogResetMode)
                   | (brownoutDetect & brownoutEnable & ~cur.bodOff);
   assign portResetForce = rawReset | cur.internalReset;

   always_comb
   begin
      case (startupTimeFuse)
         2'h0:    timeoutSel = TOUT_SUT0;
         2'h1:    timeoutSel = TOUT_SUT1;
         2'h2:    timeoutSel = TOUT_SUT2;
         default: timeoutSel = TOUT_SUT3;
      endcase
      // crystal sources need extra settling beyond the start-up choice
      if (clockSourceFuse != `CLOCK_SOURCE_FUSE_EXTERNAL_CLOCK)
      begin
         timeoutSel = timeoutSel + XTAL_EXTRA;
      end
   end

   // ****************************************************************
   // register access decode
   // ****************************************************************
   assign regWrite = dataWrite | ioWrite;
   assign regRead  = dataRead | ioRead;
   // the clock gate register sits above I/O reach, data space only
   assign regAddr  = (ioWrite | ioRead)
                   ? ({10'h000, ioAddr} + `IO_SPACE_BASE)
                   : dataAddr;

   assign bodsActive = cur.brownoutSleepOff
                     & (cur.bodsTimer <= `BROWNOUT_SLEEP_OFF_ACTIVE_CYC);
   assign bodUnlockOpen    = cur.bodUnlockTimer != 3'h0;
   assign vectorUnlockOpen = cur.vectorUnlockTimer != 3'h0;

   always_comb
   begin
      case (sleep_power_reset_control_pkg::sleep_mode_t'(cur.sleepModeField))
         sleep_power_reset_control_pkg::MODE_IDLE,
         sleep_power_reset_control_pkg::MODE_POWER_DOWN,
         sleep_power_reset_control_pkg::MODE_POWER_SAVE,
         sleep_power_reset_control_pkg::MODE_STANDBY,
         sleep_power_reset_control_pkg::MODE_EXT_STANDBY:
            modeValid = 1'b1;
         default:
            modeValid = 1'b0;
      endcase
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      next_cur = cur;

      // reset synchroniser and stretch counter
      next_cur.rstSync1 = rawReset;
      next_cur.rstSync2 = cur.rstSync1;
      if (cur.rstSync2)
      begin
         next_cur.delayCount = timeoutSel;
      end
      else if (cur.delayCount != '0)
      begin
         next_cur.delayCount = cur.delayCount - 1'b1;
      end
      next_cur.internalReset = cur.rstSync2
                             | (next_cur.delayCount != '0);

      // timed windows count down
      if (bodUnlockOpen)
      begin
         next_cur.bodUnlockTimer = cur.bodUnlockTimer - 3'h1;
      end
      if (vectorUnlockOpen)
      begin
         next_cur.vectorUnlockTimer = cur.vectorUnlockTimer - 3'h1;
      end
      if (cur.brownoutSleepOff)
      begin
         next_cur.bodsTimer = cur.bodsTimer - 3'h1;
         if (cur.bodsTimer == 3'h1)
         begin
            next_cur.brownoutSleepOff = 1'b0;
         end
      end
      if (cur.maskHold & instrRetire)
      begin
         next_cur.maskHold = 1'b0;
      end

      // register writes
      if (regWrite && regAddr == `SLEEP_MODE_CONTROL_OFS)
      begin
         next_cur.sleepEnable    = writeData[`SLEEP_ENABLE_BIT];
         next_cur.sleepModeField =
            writeData[`SLEEP_MODE_MSB:`SLEEP_MODE_LSB];
      end
      if (regWrite && regAddr == `MCU_MISC_CONTROL_OFS)
      begin
         next_cur.pullupDisable = writeData[`PULLUP_DISABLE_BIT];
         if (writeData[`BOD_SLEEP_OFF_BIT] & writeData[`BOD_UNLOCK_BIT])
         begin
            next_cur.bodUnlockTimer = `UNLOCK_WINDOW_CYC;
         end
         else
         begin
            next_cur.bodUnlockTimer = 3'h0;
            if (writeData[`BOD_SLEEP_OFF_BIT] & bodUnlockOpen)
            begin
               next_cur.brownoutSleepOff = 1'b1;
               next_cur.bodsTimer        = `BROWNOUT_SLEEP_OFF_TOTAL_CYC;
            end
         end
         if (writeData[`VECTOR_UNLOCK_BIT])
         begin
            next_cur.vectorUnlockTimer = `UNLOCK_WINDOW_CYC;
         end
         else if (vectorUnlockOpen)
         begin
            next_cur.vectorSelect      =
               writeData[`VECTOR_SELECT_BIT];
            next_cur.vectorUnlockTimer = 3'h0;
            next_cur.maskHold          = 1'b1;
         end
      end
      if (regWrite && regAddr == `PERIPHERAL_CLOCK_GATE_OFS)
      begin
         next_cur.clockGate = writeData;
      end

      // register reads, unmapped addresses answer zero
      next_cur.readData = 8'h00;
      if (regRead && regAddr == `SLEEP_MODE_CONTROL_OFS)
      begin
         next_cur.readData[`SLEEP_MODE_MSB:`SLEEP_MODE_LSB] =
            cur.sleepModeField;
         next_cur.readData[`SLEEP_ENABLE_BIT] = cur.sleepEnable;
      end
      if (regRead && regAddr == `MCU_MISC_CONTROL_OFS)
      begin
         next_cur.readData[`BOD_SLEEP_OFF_BIT]  = cur.brownoutSleepOff;
         next_cur.readData[`BOD_UNLOCK_BIT]     = bodUnlockOpen;
         next_cur.readData[`PULLUP_DISABLE_BIT] = cur.pullupDisable;
         next_cur.readData[`VECTOR_SELECT_BIT]  = cur.vectorSelect;
         next_cur.readData[`VECTOR_UNLOCK_BIT]  = vectorUnlockOpen;
      end
      if (regRead && regAddr == `PERIPHERAL_CLOCK_GATE_OFS)
      begin
         next_cur.readData = cur.clockGate;
      end

      // sleep sequencing
      case (cur.cpuState)
         sleep_power_reset_control_pkg::RUNNING:
         begin
            if (sleepInstr & cur.sleepEnable & modeValid)
            begin
               next_cur.cpuState = sleep_power_reset_control_pkg::SLEEPING;
               next_cur.bodOff   = bodsActive;
            end
         end
         sleep_power_reset_control_pkg::SLEEPING:
         begin
            if (wakeEvent)
            begin
               next_cur.cpuState = sleep_power_reset_control_pkg::WAKING;
               // standby keeps the oscillator, others restart it
               if (cur.sleepModeField[2])
               begin
                  next_cur.wakeCount = CNT_W'(`STANDBY_WAKE_CYC);
               end
               else
               begin
                  next_cur.wakeCount = timeoutSel;
               end
            end
         end
         sleep_power_reset_control_pkg::WAKING:
         begin
            next_cur.wakeCount = cur.wakeCount - 1'b1;
            if (cur.wakeCount <= {{(CNT_W-1){1'b0}}, 1'b1})
            begin
               next_cur.cpuState = sleep_power_reset_control_pkg::RUNNING;
               next_cur.bodOff   = 1'b0;
            end
         end
         default:
         begin
            next_cur.cpuState = sleep_power_reset_control_pkg::RUNNING;
         end
      endcase

      // any reset returns all control registers to initial values
      if (cur.internalReset)
      begin
         next_cur.sleepModeField    = 3'h0;
         next_cur.sleepEnable       = 1'b0;
         next_cur.brownoutSleepOff  = 1'b0;
         next_cur.bodsTimer         = 3'h0;
         next_cur.bodUnlockTimer    = 3'h0;
         next_cur.pullupDisable     = 1'b0;
         next_cur.vectorSelect      = 1'b0;
         next_cur.vectorUnlockTimer = 3'h0;
         next_cur.maskHold          = 1'b0;
         next_cur.clockGate         = `REG_RESET_VALUE;
         next_cur.readData          = `REG_RESET_VALUE;
         next_cur.cpuState  = sleep_power_reset_control_pkg::RUNNING;
         next_cur.wakeCount = '0;
         next_cur.bodOff    = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur <= '{
            sleepModeField:    3'h0,
            sleepEnable:       1'b0,
            brownoutSleepOff:  1'b0,
            bodsTimer:         3'h0,
            bodUnlockTimer:    3'h0,
            pullupDisable:     1'b0,
            vectorSelect:      1'b0,
            vectorUnlockTimer: 3'h0,
            maskHold:          1'b0,
            clockGate:         `REG_RESET_VALUE,
            readData:          `REG_RESET_VALUE,
            cpuState:  sleep_power_reset_control_pkg::RUNNING,
            wakeCount:         '0,
            bodOff:            1'b0,
            rstSync1:          1'b1,
            rstSync2:          1'b1,
            delayCount:        '0,
            internalReset:     1'b1
         };
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign readData           = cur.readData;
   assign sleepModeField     = cur.sleepModeField;
   assign internalReset      = cur.internalReset;
   assign cpuHalt = cur.cpuState != sleep_power_reset_control_pkg::RUNNING;
   assign brownoutDetectorOn = brownoutEnable & ~cur.bodOff;

   genvar pin;
   generate
      for (pin = 0; pin < PIN_N; pin++)
      begin : g_pullup
         assign pullupEnable[pin] = ~pinDirection[pin] & pinOutputValue[pin]
                                  & ~cur.pullupDisable
                                  & ~portResetForce;
      end
   endgenerate

   always_comb
   begin
      case (bootAreaSizeFuse)
         2'h0:    vectorBase = BOOT_BASE0;
         2'h1:    vectorBase = BOOT_BASE1;
         2'h2:    vectorBase = BOOT_BASE2;
         default: vectorBase = BOOT_BASE3;
      endcase
      if (!cur.vectorSelect)
      begin
         vectorBase = 15'h0000;
      end
   end

   // auto mask leaves the global interrupt flag alone, it only blocks
   assign interruptBlock = vectorUnlockOpen | cur.maskHold
      | (cur.vectorSelect & appSideBootLock & ~execFromBoot)
      | (~cur.vectorSelect & bootSideBootLock & execFromBoot);

   // gating freezes state; clearing a bit resumes where it stopped
   assign gateTwoWire0          = cur.clockGate[`GATE_TWO_WIRE_0_BIT];
   assign gateTimer2            = cur.clockGate[`GATE_TIMER_2_BIT]
                                & ~timer2AsyncSelect;
   assign gateTimer0            = cur.clockGate[`GATE_TIMER_0_BIT];
   assign gateSerialPort1       = cur.clockGate[`GATE_SERIAL_PORT_1_BIT];
   assign gateTimer1            = cur.clockGate[`GATE_TIMER_1_BIT];
   assign gateSerialPeripheral0 = cur.clockGate[`GATE_SERIAL_PERIPH_0_BIT];
   assign gateSerialPort0       = cur.clockGate[`GATE_SERIAL_PORT_0_BIT];
   assign gateConverter         = cur.clockGate[`GATE_CONVERTER_BIT];
   assign comparatorMuxBlock    = cur.clockGate[`GATE_CONVERTER_BIT];

endmodule // sleep_power_reset_control
`default_nettype wire

/* File: logic/sleep_power_reset_control_defines.svh */
`ifndef SLEEP_POWER_RESET_CONTROL_DEFINES_SVH
`define SLEEP_POWER_RESET_CONTROL_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define SLEEP_MODE_CONTROL_OFS    16'h0053
`define MCU_MISC_CONTROL_OFS      16'h0055
`define PERIPHERAL_CLOCK_GATE_OFS 16'h0064
`define IO_SPACE_BASE             16'h0020
`define REG_RESET_VALUE           8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define SLEEP_ENABLE_BIT          0
`define SLEEP_MODE_LSB            1
`define SLEEP_MODE_MSB            3
`define VECTOR_UNLOCK_BIT         0
`define VECTOR_SELECT_BIT         1
`define PULLUP_DISABLE_BIT        4
`define BOD_UNLOCK_BIT            5
`define BOD_SLEEP_OFF_BIT         6
`define GATE_CONVERTER_BIT        0
`define GATE_SERIAL_PORT_0_BIT    1
`define GATE_SERIAL_PERIPH_0_BIT  2
`define GATE_TIMER_1_BIT          3
`define GATE_SERIAL_PORT_1_BIT    4
`define GATE_TIMER_0_BIT          5
`define GATE_TIMER_2_BIT          6
`define GATE_TWO_WIRE_0_BIT       7

// ****************************************************************
// timing in clock cycles, and the external clock fuse code
// ****************************************************************
`define UNLOCK_WINDOW_CYC         3'h4
`define BROWNOUT_SLEEP_OFF_TOTAL_CYC            3'h6
`define BROWNOUT_SLEEP_OFF_ACTIVE_CYC           3'h3
`define STANDBY_WAKE_CYC          20'h00006
`define CLOCK_SOURCE_FUSE_EXTERNAL_CLOCK      4'h0

`endif

/* File: logic/sleep_power_reset_control_pkg.sv */
package sleep_power_reset_control_pkg;

   typedef enum logic [2:0]
   {
      MODE_IDLE        = 3'h0,
      MODE_NOISE       = 3'h1,
      MODE_POWER_DOWN  = 3'h2,
      MODE_POWER_SAVE  = 3'h3,
      MODE_RESERVED_4  = 3'h4,
      MODE_RESERVED_5  = 3'h5,
      MODE_STANDBY     = 3'h6,
      MODE_EXT_STANDBY = 3'h7
   } sleep_mode_t;

   typedef enum logic [1:0]
   {
      RUNNING,
      SLEEPING,
      WAKING
   } cpu_state_t;

endpackage

/* File: tb/sleep_power_reset_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_power_reset_control_props
#(
   parameter int unsigned PIN_N = 8
)
(
   input wire logic             clock,
   input wire logic             rst_n,
   input wire logic [7:0]       readData,
   input wire logic             dataRead,
   input wire logic             ioRead,
   input wire logic [PIN_N-1:0] pullupEnable,
   input wire logic             portResetForce,
   input wire logic             internalReset,
   input wire logic             powerOnDetect,
   input wire logic             timer2AsyncSelect,
   input wire logic             gateTimer2,
   input wire logic             gateConverter,
   input wire logic             comparatorMuxBlock,
   input wire logic             brownoutEnable,
   input wire logic             brownoutDetectorOn,
   input wire logic [14:0]      vectorBase
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_pu; portResetForce |-> pullupEnable == '0; endproperty
   a_pu: assert property (p_pu) else $error("pull-up in reset");
   property p_src; powerOnDetect |-> portResetForce; endproperty
   a_src: assert property (p_src) else $error("pins not forced");
   property p_por; powerOnDetect |-> ##[1:4] internalReset; endproperty
   a_por: assert property (p_por) else $error("no reset");
   property p_t2; timer2AsyncSelect |-> !gateTimer2; endproperty
   a_t2: assert property (p_t2) else $error("async gated");
   property p_cmp; comparatorMuxBlock == gateConverter; endproperty
   a_cmp: assert property (p_cmp) else $error("mux block");
   property p_rd; !$past(dataRead) && !$past(ioRead) |-> readData == 8'h00;
   endproperty
   a_rd: assert property (p_rd) else $error("read data stays");
   property p_bod; !brownoutEnable |-> !brownoutDetectorOn; endproperty
   a_bod: assert property (p_bod) else $error("detector on");
   property p_clr; internalReset && $past(internalReset) |->
      vectorBase == 15'h0000 && !gateConverter; endproperty
   a_clr: assert property (p_clr) else $error("not cleared");
endmodule // sleep_power_reset_control_props
bind sleep_power_reset_control sleep_power_reset_control_props
   #(.PIN_N(PIN_N)) chk_u (.clock, .rst_n, .readData, .dataRead, .ioRead,
   .pullupEnable, .portResetForce, .internalReset, .powerOnDetect,
   .timer2AsyncSelect, .gateTimer2, .gateConverter, .comparatorMuxBlock,
   .brownoutEnable, .brownoutDetectorOn, .vectorBase);
`default_nettype wire

/* File: tb/tb_sleep_power_reset_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_power_reset_control;
   localparam logic [14:0] BB0 = 15'h3f00;
   typedef struct packed {logic io; logic [15:0] a; logic [7:0] d, e;} row_t;
   row_t rows [7] = '{{1'b0,16'h0053,8'hff,8'h0f}, {1'b1,16'h0053,8'h05,8'h05},
      {1'b0,16'h0055,8'h9c,8'h10}, {1'b1,16'h0055,8'h00,8'h00},
      {1'b1,16'h0064,8'hff,8'h00}, {1'b0,16'h0064,8'ha5,8'ha5},
      {1'b0,16'h0060,8'hff,8'h00}};
   logic [3:0] src [4] = '{4'b1000, 4'b0110, 4'b0001, 4'b0100};
   logic clock = 0, rst_n = 0, dataWrite = 0, dataRead = 0, ioWrite = 0;
   logic ioRead = 0, sleepInstr = 0, wakeEvent = 0, instrRetire = 0;
   logic appSideBootLock = 0, bootSideBootLock = 0, execFromBoot = 0;
   logic timer2AsyncSelect = 0, powerOnDetect = 0, extReset_n = 1;
   logic watchdogExpire = 0, watchdogResetMode = 0, brownoutDetect = 0;
   logic brownoutEnable = 1;
   logic [15:0] dataAddr = 0;
   logic [5:0]  ioAddr = 0;
   logic [7:0]  writeData = 0, pinDirection = 0, pinOutputValue = 8'hff, rv;
   logic [1:0]  bootAreaSizeFuse = 0, startupTimeFuse = 0;
   logic [3:0]  clockSourceFuse = 0;
   logic [7:0]  readData, pullupEnable, gv;
   logic [2:0]  sleepModeField;
   logic [14:0] vectorBase;
   logic cpuHalt, brownoutDetectorOn, portResetForce, interruptBlock;
   logic internalReset, comparatorMuxBlock, gateTwoWire0, gateTimer2;
   logic gateTimer0, gateSerialPort1, gateTimer1, gateSerialPeripheral0;
   logic gateSerialPort0, gateConverter;
   int errors = 0, total_checks = 0, i, n;
   assign gv = {gateTwoWire0, gateTimer2, gateTimer0, gateSerialPort1,
      gateTimer1, gateSerialPeripheral0, gateSerialPort0, gateConverter};
   sleep_power_reset_control #(.TOUT_SUT0(20'h00006), .TOUT_SUT1(20'h0000a),
      .TOUT_SUT2(20'h00014), .TOUT_SUT3(20'h00006), .XTAL_EXTRA(20'h00004),
      .BOOT_BASE0(BB0)) dut_u (.clock, .rst_n, .dataAddr, .dataWrite,
      .dataRead, .ioAddr, .ioWrite, .ioRead, .writeData, .readData,
      .sleepInstr, .wakeEvent, .instrRetire, .cpuHalt, .sleepModeField,
      .brownoutDetectorOn, .pinDirection, .pinOutputValue, .pullupEnable,
      .portResetForce, .bootAreaSizeFuse, .appSideBootLock, .bootSideBootLock,
      .execFromBoot, .vectorBase, .interruptBlock, .timer2AsyncSelect,
      .gateTwoWire0, .gateTimer2, .gateTimer0, .gateSerialPort1, .gateTimer1,
      .gateSerialPeripheral0, .gateSerialPort0, .gateConverter,
      .comparatorMuxBlock, .powerOnDetect, .extReset_n, .watchdogExpire,
      .watchdogResetMode, .brownoutDetect, .brownoutEnable, .startupTimeFuse,
      .clockSourceFuse, .internalReset);
   always #50 clock = ~clock;
   task automatic chk(input logic [14:0] g, input logic [14:0] e);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // io accesses reach registers up to 0x5f at offset minus 0x20; 0x64 is out of io reach
   task automatic acc(input logic io, w, input logic [15:0] a, logic [7:0] d);
      @(negedge clock);
      ioAddr = 6'(a - 16'h0020);
      dataAddr = a;
      writeData = d;
      {ioWrite, ioRead, dataWrite, dataRead} =
         {io & w, io & !w, !io & w, !io & !w};
      @(negedge clock);
      rv = readData;
      {ioWrite, ioRead, dataWrite, dataRead} = 4'h0;
   endtask
   task automatic slp(input int w);
      repeat (w) @(negedge clock);
      sleepInstr = 1;
      @(negedge clock);
      sleepInstr = 0;
   endtask
   // bounded: a stuck reset shows up as a failed compare, not a hang
   task automatic wait_run();
      n = 0;
      while (internalReset !== 1'b0 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200000;
      errors++;
      close_out();
   end
   initial
   begin
      #2000 rst_n = 1;
      wait_run();
      acc(0, 0, 16'h0053, 8'h00);
      chk(rv, 8'h00);
      acc(0, 0, 16'h0055, 8'h00);
      chk(rv, 8'h00);
      for (i = 0; i < 7; i++)
      begin
         acc(rows[i].io, 1, rows[i].a, rows[i].d);
         acc(rows[i].io, 0, rows[i].a, 8'h00);
         chk(rv, rows[i].e);
      end
      for (i = 0; i < 8; i++)
      begin
         acc(0, 1, 16'h0064, 8'h01 << i);
         chk(gv, 8'h01 << i);
         chk(comparatorMuxBlock, i == 0);
      end
      acc(0, 1, 16'h0064, 8'h40);
      chk(gateTimer2, 1);
      timer2AsyncSelect = 1;
      #1 chk(gateTimer2, 0);
      timer2AsyncSelect = 0;
      pinDirection = 8'h0f;
      acc(0, 1, 16'h0055, 8'h00);
      chk(pullupEnable, 8'hf0);
      acc(0, 1, 16'h0055, 8'h10);
      chk(pullupEnable, 8'h00);
      acc(0, 1, 16'h0055, 8'h01);
      chk(interruptBlock, 1);
      acc(0, 1, 16'h0055, 8'h02);
      chk(vectorBase, BB0);
      chk(interruptBlock, 1);
      @(negedge clock);
      instrRetire = 1;
      @(negedge clock) instrRetire = 0;
      repeat (2) @(negedge clock);
      chk(interruptBlock, 0);
      appSideBootLock = 1;
      #1 chk(interruptBlock, 1);
      execFromBoot = 1;
      #1 chk(interruptBlock, 0);
      appSideBootLock = 0;
      acc(0, 1, 16'h0055, 8'h00);
      chk(vectorBase, BB0);
      acc(0, 1, 16'h0055, 8'h01);
      repeat (4) @(negedge clock);
      chk(interruptBlock, 0);
      acc(0, 1, 16'h0055, 8'h00);
      chk(vectorBase, BB0);
      for (i = 0; i < 3; i++)
      begin
         acc(0, 1, 16'h0053, i == 0 ? 8'h0c : i == 1 ? 8'h09 : 8'h0b);
         slp(1);
         chk(cpuHalt, 0);
      end
      acc(0, 1, 16'h0053, 8'h0d);
      acc(0, 1, 16'h0055, 8'h60);
      acc(0, 1, 16'h0055, 8'h40);
      slp(4);
      chk(cpuHalt, 1);
      chk(sleepModeField, 3'h6);
      chk(brownoutDetectorOn, 0);
      wakeEvent = 1;
      @(negedge clock) wakeEvent = 0;
      repeat (5) @(negedge clock);
      chk(cpuHalt, 1);
      @(negedge clock);
      chk(cpuHalt, 0);
      slp(1);
      chk(brownoutDetectorOn, 1);
      wakeEvent = 1;
      repeat (12) @(negedge clock);
      wakeEvent = 0;
      extReset_n = 0;
      #1 chk(portResetForce, 1);
      repeat (3) @(negedge clock);
      extReset_n = 1;
      wait_run();
      chk(n >= 6 && n < 100, 1);
      acc(0, 0, 16'h0064, 8'h00);
      chk(rv, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         {powerOnDetect, watchdogExpire, watchdogResetMode, brownoutDetect} =
            src[i];
         repeat (4) @(negedge clock);
         chk(internalReset, i != 3);
         {powerOnDetect, watchdogExpire, watchdogResetMode, brownoutDetect} =
            4'h0;
         wait_run();
      end
      close_out();
   end
endmodule // tb_sleep_power_reset_control
`default_nettype wire
